// ==== cst_pkg.sv ====
// Constants, field layout and types shared by the converter status logic.
package cst_pkg;

    // ------------------------------------------------------------------
    // Command byte layout
    // ------------------------------------------------------------------
    localparam int             CMD_WEN_BIT = 7;
    localparam int             CMD_RW_BIT  = 6;
    localparam int             SEL_W       = 6;

    // ------------------------------------------------------------------
    // Register selects
    // ------------------------------------------------------------------
    localparam logic [5:0]     STATUS_SEL  = 6'h00;
    localparam logic [5:0]     DATA_SEL    = 6'h02;

    // ------------------------------------------------------------------
    // Status register layout and reset values
    // ------------------------------------------------------------------
    localparam int             RDY_BIT      = 7;
    localparam int             ERR_BIT      = 6;
    localparam int             RSVD_BIT     = 5;
    localparam int             POR_BIT      = 4;
    localparam int             CH_W         = 4;
    localparam logic [7:0]     STATUS_RESET = 8'h10;
    localparam logic           RDY_RESET    = STATUS_RESET[RDY_BIT];
    localparam logic           ERR_RESET    = STATUS_RESET[ERR_BIT];
    localparam logic           POR_RESET    = STATUS_RESET[POR_BIT];
    localparam logic [3:0]     CH_RESET     = STATUS_RESET[3:0];
    localparam logic           RSVD_VALUE   = 1'b0;

    // ------------------------------------------------------------------
    // Data widths
    // ------------------------------------------------------------------
    localparam int             RESULT_W     = 16;
    localparam int             ERR_W        = 8;
    localparam logic [15:0]    RESULT_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int             REF_CLK_PERIOD_NS = 40;
    localparam int             MCLK_PERIOD_NS    = 40;
    localparam int             WARN_MCLK_CYCLES  = 4;
    localparam int             WARN_CYCLES_INT   =
        (WARN_MCLK_CYCLES * MCLK_PERIOD_NS + REF_CLK_PERIOD_NS - 1)
        / REF_CLK_PERIOD_NS;
    localparam logic [2:0]     WARN_CYCLES       = 3'(WARN_CYCLES_INT);
    localparam logic [2:0]     WARN_IDLE         = 3'h0;
    localparam logic [2:0]     WARN_LAST         = 3'h1;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        RD_IDLE,
        RD_BUSY
    } cst_rd_state_type;

endpackage

// ==== cst_sync2.sv ====
// Two-flop synchroniser for one level arriving from a pin.
`timescale 1ns/1ns
module cst_sync2
    import cst_pkg::*;
#(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic ref_clk,   // Core clock.
    input  wire logic resetn,    // Asynchronous reset, active low.
    input  wire logic clk_en,    // Freezes the flops while low.
    input  wire logic async_in,  // Level from outside the clock domain.
    output logic      sync_out   // Level safe to read in the domain.
);

    logic meta_r;
    logic sync_r;

    // ------------------------------------------------------------------
    // Synchroniser stages
    // ------------------------------------------------------------------
    // The first stage is read by the second stage only.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= RESET_VAL;
            sync_r <= RESET_VAL;
        end else if (clk_en) begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule

// ==== cst_result_store.sv ====
// Data register holding the last conversion result and its channel.
`timescale 1ns/1ns
module cst_result_store
    import cst_pkg::*;
(
    input  wire logic                ref_clk,   // Core clock.
    input  wire logic                resetn,    // Asynchronous reset, low.
    input  wire logic                clk_en,    // Freezes state while low.
    input  wire logic                wr_en,     // Commit a new result.
    input  wire logic [RESULT_W-1:0] wr_data,   // Result to store.
    input  wire logic [CH_W-1:0]     wr_chan,   // Channel of that result.
    input  wire logic                rd_en,     // Fetch stored result.
    output logic      [RESULT_W-1:0] rd_data,   // Registered read data.
    output logic      [CH_W-1:0]     chan       // Channel of stored result.
);

    logic [RESULT_W-1:0] data_r;
    logic [CH_W-1:0]     chan_r;
    logic [RESULT_W-1:0] rd_data_r;

    // ------------------------------------------------------------------
    // Storage and registered read port
    // ------------------------------------------------------------------
    // A read in the same cycle as a write returns the older value.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            data_r    <= RESULT_RESET;
            chan_r    <= CH_RESET;
            rd_data_r <= RESULT_RESET;
        end else if (clk_en) begin
            if (wr_en) begin
                data_r <= wr_data;
                chan_r <= wr_chan;
            end
            if (rd_en) begin
                rd_data_r <= data_r;
            end
        end
    end

    assign rd_data = rd_data_r;
    assign chan    = chan_r;

endmodule

// ==== cst_status_top.sv ====
// Converter status register, data-ready pin and result hand-off logic.
//
// Overview of operation
// - Committing a new conversion result drives the ready bit to 0.
// - A calibration coefficient write also drives the ready bit to 0.
// - A data register read returns the ready bit to 1; other reads do not.
// - Idle or standby entry, calibration start and conversion start set 1.
// - A falling restart pin sets the ready bit to 1 if the data is unread.
// - The ready bit goes to 1 four modulator cycles before a result commit.
// - A result that lands during a data register read is dropped whole.
// - The data-ready pin is low while the ready bit is 0, high otherwise.
// - The error bit is the OR of all error register bits, self-clearing.
// - The error bit is mirrored to the sample queue status register.
// - The power-on flag is 1 after any reset, its reset value being 1.
// - A host read of the status register clears the power-on flag.
// - The channel field names the channel of the stored result.
// - The channel field is the plain binary channel index 0 to 15.
// - Status sits at select 0x00, resets to 0x10, is read-only, bit 5 is 0.
`timescale 1ns/1ns
module cst_status_top
    import cst_pkg::*;
(
    input  wire logic                ref_clk,         // Core clock, 25 MHz.
    input  wire logic                resetn,          // Power-on reset, low.
    input  wire logic                clk_en,          // Freezes all state.
    input  wire logic                cmd_valid,       // Command byte strobe.
    input  wire logic [7:0]          cmd_byte,        // Command byte.
    input  wire logic                read_done,       // Read transfer over.
    input  wire logic                result_valid,    // New result strobe.
    input  wire logic [RESULT_W-1:0] result_data,     // New result value.
    input  wire logic [CH_W-1:0]     result_channel,  // Channel of result.
    input  wire logic                cal_coeff_write, // Coefficients stored.
    input  wire logic                cal_start,       // Calibration begins.
    input  wire logic                idle_entry,      // Idle or standby.
    input  wire logic                conv_start,      // Conversion begins.
    input  wire logic                restart_n,       // Restart pin, low.
    input  wire logic [ERR_W-1:0]    error_bits,      // Error register.
    output logic                     data_ready_n,    // Data-ready pin.
    output logic      [7:0]          status_rdata,    // Status read data.
    output logic                     status_rvalid,   // Status data pulse.
    output logic      [RESULT_W-1:0] data_rdata,      // Data read data.
    output logic                     data_rvalid,     // Data read pulse.
    output logic                     read_active,     // Data read running.
    output logic                     fifo_ctrl_err,   // Error to queue.
    output logic                     result_dropped   // Result lost pulse.
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    cst_rd_state_type    rd_state_r;
    cst_rd_state_type    rd_state_nxt;
    logic                conversion_ready_n_r;
    logic                conversion_ready_n_nxt;
    logic                por_flag_r;
    logic                err_agg_r;
    logic                unread_r;
    logic                unread_nxt;
    logic [2:0]          warn_cnt_r;
    logic [2:0]          warn_cnt_nxt;
    logic [RESULT_W-1:0] hold_data_r;
    logic [CH_W-1:0]     hold_chan_r;
    logic                restart_q;
    logic                restart_prev_r;
    logic [7:0]          status_rdata_r;
    logic                status_rvalid_r;
    logic                data_rd_pend_r;
    logic                result_dropped_r;
    logic [RESULT_W-1:0] store_rd_data;
    logic [CH_W-1:0]     result_channel_index;
    logic                data_ready_n_r;

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    // Only a command byte that opens with a 0 is acted upon.
    wire             cmd_allowed   = cmd_valid
                                   & ~cmd_byte[CMD_WEN_BIT];
    wire             cmd_is_read   = cmd_byte[CMD_RW_BIT];
    wire [SEL_W-1:0] register_select = cmd_byte[SEL_W-1:0];
    wire             status_read   = cmd_allowed & cmd_is_read
                                   & (register_select == STATUS_SEL);
    wire             data_read     = cmd_allowed & cmd_is_read
                                   & (register_select == DATA_SEL);
    // Writes to the status select are accepted by framing but change nothing.
    wire             reading_data  = (rd_state_r == RD_BUSY);

    // ------------------------------------------------------------------
    // Result commit timing
    // ------------------------------------------------------------------
    // The countdown runs while a result waits to be committed.
    wire warn_running  = (warn_cnt_r != WARN_IDLE);
    wire commit_due    = (warn_cnt_r == WARN_LAST) & ~result_valid;
    wire commit_abort  = commit_due & (reading_data | data_read);
    wire commit_write  = commit_due & ~commit_abort;

    // ------------------------------------------------------------------
    // Restart pin edge
    // ------------------------------------------------------------------
    wire restart_fall  = restart_prev_r & ~restart_q;

    // ------------------------------------------------------------------
    // Status byte as seen by the host
    // ------------------------------------------------------------------
    wire [7:0] status_word = {conversion_ready_n_r,
                              err_agg_r,
                              RSVD_VALUE,
                              por_flag_r,
                              result_channel_index};

    // ------------------------------------------------------------------
    // Synchroniser for the restart pin
    // ------------------------------------------------------------------
    cst_sync2 #(
        .RESET_VAL (1'b1)
    ) u_restart_sync (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .clk_en   (clk_en),
        .async_in (restart_n),
        .sync_out (restart_q)
    );

    // ------------------------------------------------------------------
    // Data register
    // ------------------------------------------------------------------
    cst_result_store u_store (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .clk_en  (clk_en),
        .wr_en   (commit_write),
        .wr_data (hold_data_r),
        .wr_chan (hold_chan_r),
        .rd_en   (data_read),
        .rd_data (store_rd_data),
        .chan    (result_channel_index)
    );

    // ------------------------------------------------------------------
    // Countdown before a commit
    // ------------------------------------------------------------------
    // A fresh result restarts the countdown; a newer one replaces the old.
    always_comb begin
        warn_cnt_nxt = warn_cnt_r;
        if (result_valid) begin
            warn_cnt_nxt = WARN_CYCLES;
        end else if (warn_running) begin
            warn_cnt_nxt = warn_cnt_r - 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // Data read tracking
    // ------------------------------------------------------------------
    // The read stays open from its command until framing reports the end.
    always_comb begin
        rd_state_nxt = rd_state_r;
        unique case (rd_state_r)
            RD_IDLE: begin
                if (data_read) begin
                    rd_state_nxt = RD_BUSY;
                end
            end
            RD_BUSY: begin
                if (read_done) begin
                    rd_state_nxt = RD_IDLE;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Unread-data tracking
    // ------------------------------------------------------------------
    // A commit in the same cycle as a read command cannot happen, since
    // the read aborts it.
    always_comb begin
        unread_nxt = unread_r;
        if (commit_write) begin
            unread_nxt = 1'b1;
        end else if (data_read) begin
            unread_nxt = 1'b0;
        end else if (restart_fall) begin
            unread_nxt = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Conversion-ready indicator
    // ------------------------------------------------------------------
    // New data beats every event that would mark the data not ready.
    always_comb begin
        conversion_ready_n_nxt = conversion_ready_n_r;
        if (commit_write) begin
            conversion_ready_n_nxt = 1'b0;
        end else if (cal_coeff_write) begin
            conversion_ready_n_nxt = 1'b0;
        end else if (data_read) begin
            conversion_ready_n_nxt = 1'b1;
        end else if (idle_entry | cal_start | conv_start) begin
            conversion_ready_n_nxt = 1'b1;
        end else if (restart_fall & unread_r) begin
            conversion_ready_n_nxt = 1'b1;
        end else if (result_valid) begin
            conversion_ready_n_nxt = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Core state registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rd_state_r           <= RD_IDLE;
            conversion_ready_n_r <= RDY_RESET;
            unread_r             <= 1'b0;
            warn_cnt_r           <= WARN_IDLE;
            restart_prev_r       <= 1'b1;
        end else if (clk_en) begin
            rd_state_r           <= rd_state_nxt;
            conversion_ready_n_r <= conversion_ready_n_nxt;
            unread_r             <= unread_nxt;
            warn_cnt_r           <= warn_cnt_nxt;
            restart_prev_r       <= restart_q;
        end
    end

    // ------------------------------------------------------------------
    // Pending result holding registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            hold_data_r <= RESULT_RESET;
            hold_chan_r <= CH_RESET;
        end else if (clk_en && result_valid) begin
            hold_data_r <= result_data;
            hold_chan_r <= result_channel;
        end
    end

    // ------------------------------------------------------------------
    // Power-on flag and aggregate error
    // ------------------------------------------------------------------
    // Reset itself is the power-on event, so no set term is needed here.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            por_flag_r <= POR_RESET;
            err_agg_r  <= ERR_RESET;
        end else if (clk_en) begin
            if (status_read) begin
                por_flag_r <= 1'b0;
            end
            err_agg_r <= |error_bits;
        end
    end

    // ------------------------------------------------------------------
    // Host read data and pin outputs
    // ------------------------------------------------------------------
    // The status snapshot is taken before the read clears the flag.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            status_rdata_r   <= STATUS_RESET;
            status_rvalid_r  <= 1'b0;
            data_rd_pend_r   <= 1'b0;
            result_dropped_r <= 1'b0;
            data_ready_n_r   <= RDY_RESET;
        end else if (clk_en) begin
            if (status_read) begin
                status_rdata_r <= status_word;
            end
            status_rvalid_r  <= status_read;
            data_rd_pend_r   <= data_read;
            result_dropped_r <= commit_abort;
            data_ready_n_r   <= conversion_ready_n_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Output assignments
    // ------------------------------------------------------------------
    // The error mirror and read flag are flops; the pin tracks the bit.
    assign data_ready_n   = data_ready_n_r;
    assign status_rdata   = status_rdata_r;
    assign status_rvalid  = status_rvalid_r;
    assign data_rdata     = store_rd_data;
    assign data_rvalid    = data_rd_pend_r;
    assign read_active    = (rd_state_r == RD_BUSY);
    assign fifo_ctrl_err  = err_agg_r;
    assign result_dropped = result_dropped_r;

endmodule

// ==== cst_host_model.sv ====
// Host model that opens every access with a command byte.
`timescale 1ns/1ns
module cst_host_model (
    input  wire logic       ref_clk,    // Core clock.
    output logic            cmd_valid,  // Command byte strobe.
    output logic      [7:0] cmd_byte,   // Command byte.
    output logic            read_done   // Data transfer finished.
);
    // Idle values at time zero.
    initial begin
        cmd_valid = 1'b0;
        cmd_byte  = 8'h80;
        read_done = 1'b0;
    end
    // Sends one command byte, then leaves a changing pattern behind.
    task automatic send(input logic rw, input logic [5:0] sel,
                        input logic dis);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_byte  <= {dis, rw, sel};
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        cmd_byte  <= ~{dis, rw, sel};
    endtask
    // Closes an open data transfer with a one-cycle pulse.
    task automatic finish;
        @(posedge ref_clk);
        read_done <= 1'b1;
        @(posedge ref_clk);
        read_done <= 1'b0;
    endtask
endmodule

// ==== cst_status_asserts.sv ====
// Checker of the converter status block port behaviour.
`timescale 1ns/1ns
module cst_status_asserts
    import cst_pkg::*;
(
    input wire logic       ref_clk,         // Core clock.
    input wire logic       resetn,          // Reset, active low.
    input wire logic       clk_en,          // Run enable.
    input wire logic       cmd_valid,       // Command strobe.
    input wire logic [7:0] cmd_byte,        // Command byte.
    input wire logic       result_valid,    // New result.
    input wire logic       cal_coeff_write, // Coefficient write.
    input wire logic [7:0] error_bits,      // Error register.
    input wire logic       data_ready_n,    // Data-ready pin.
    input wire logic [7:0] status_rdata,    // Status data.
    input wire logic       status_rvalid,   // Status pulse.
    input wire logic       data_rvalid,     // Data pulse.
    input wire logic       read_active,     // Data read open.
    input wire logic       fifo_ctrl_err,   // Error mirror.
    input wire logic       result_dropped   // Result lost.
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // Command decode and quiet-cycle qualifiers.
    wire cmd_ok = cmd_valid && clk_en && !cmd_byte[CMD_WEN_BIT];
    wire rd_ok  = cmd_ok && cmd_byte[CMD_RW_BIT];
    wire st_rd  = rd_ok && cmd_byte[5:0] == STATUS_SEL;
    wire dt_rd  = rd_ok && cmd_byte[5:0] == DATA_SEL && !cal_coeff_write;
    wire calm   = clk_en && !cal_coeff_write && !cmd_valid && !read_active;
    wire quiet  = calm && !result_valid;
    wire any_err = |error_bits;
    // A result arrival followed by four undisturbed cycles.
    sequence warn_s;
        result_valid && calm ##1 quiet [*4];
    endsequence
    // Two status reads with no reset between them.
    sequence two_reads_s;
        status_rvalid ##[1:40] status_rvalid;
    endsequence
    status_ans_a: assert property (st_rd |=> status_rvalid)
        else $error("status read not answered");
    data_ans_a: assert property (dt_rd |=> data_rvalid && read_active
        && data_ready_n) else $error("data read answer wrong");
    refuse_a: assert property (cmd_valid && clk_en && (cmd_byte[7]
        || !cmd_byte[6]) |=> !status_rvalid && !data_rvalid)
        else $error("refused command answered");
    snap_a: assert property (status_rvalid |-> !status_rdata[RSVD_BIT]
        && status_rdata[RDY_BIT] == $past(data_ready_n))
        else $error("status snapshot wrong");
    por_clear_a: assert property (two_reads_s |-> !status_rdata[POR_BIT])
        else $error("power-on flag not cleared");
    err_mirror_a: assert property ($past(clk_en) && $past(resetn)
        |-> fifo_ctrl_err == $past(any_err)) else $error("error mirror");
    cal_clear_a: assert property (cal_coeff_write && clk_en
        |=> !data_ready_n) else $error("ready not set by calibration");
    commit_a: assert property (warn_s |-> data_ready_n ##1 !data_ready_n)
        else $error("result commit timing wrong");
    drop_a: assert property (result_dropped |-> $past(read_active)
        || data_rvalid) else $error("drop without read");
endmodule
bind cst_status_top cst_status_asserts u_chk (.ref_clk, .resetn, .clk_en,
    .cmd_valid, .cmd_byte, .result_valid, .cal_coeff_write, .error_bits,
    .data_ready_n, .status_rdata, .status_rvalid, .data_rvalid,
    .read_active, .fifo_ctrl_err, .result_dropped);

// ==== cst_status_top_bench.sv ====
// Self-checking bench for the converter status block.
`timescale 1ns/1ns
module cst_status_top_bench;
    import cst_pkg::*;
    logic        ref_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1;
    logic        cmd_valid, read_done, result_valid, cal_coeff_write;
    logic        restart_n, data_ready_n, status_rvalid, data_rvalid;
    logic        read_active, fifo_ctrl_err, result_dropped;
    logic [2:0]  ev;        // Idle, calibration start, conversion start.
    logic [3:0]  result_channel;
    logic [7:0]  cmd_byte, error_bits, status_rdata;
    logic [15:0] result_data, data_rdata, d, old_d;
    int          n_errors = 0, total_checks = 0, cycles = 0;
    integer      seed = 32'hf5f9a013;
    // Clock at 25 MHz.
    always #20 ref_clk = ~ref_clk;
    cst_status_top u_cst_status_top (.ref_clk, .resetn, .clk_en,
        .cmd_valid, .cmd_byte, .read_done, .result_valid, .result_data,
        .result_channel, .cal_coeff_write, .cal_start(ev[1]),
        .idle_entry(ev[0]), .conv_start(ev[2]), .restart_n, .error_bits,
        .data_ready_n, .status_rdata, .status_rvalid, .data_rdata,
        .data_rvalid, .read_active, .fifo_ctrl_err, .result_dropped);
    cst_host_model u_cst_host_model (.ref_clk, .cmd_valid, .cmd_byte,
        .read_done);
    // Verdict and end of run.
    task automatic end_sim;
        if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Compares one value and reports a mismatch.
    task automatic check(input string what, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Expected status byte.
    function automatic logic [7:0] st_exp(input logic r, e, p,
                                          input logic [3:0] c);
        return {r, e, 1'b0, p, c};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Reads the status register and compares it.
    task automatic rd_status(input logic [7:0] exp);
        u_cst_host_model.send(1'b1, STATUS_SEL, 1'b0);
        #1;
        check("status valid", 16'(status_rvalid), 16'h1);
        check("status byte", 16'(status_rdata), 16'(exp));
    endtask
    // Reads the data register and closes the transfer.
    task automatic rd_data(input logic [15:0] exp);
        u_cst_host_model.send(1'b1, DATA_SEL, 1'b0);
        #1;
        check("data", data_rvalid ? data_rdata : ~exp, exp);
        check("ready after read", 16'(data_ready_n), 16'h1);
        u_cst_host_model.finish;
    endtask
    // Presents one result for one cycle.
    task automatic push(input logic [15:0] v, input logic [3:0] c);
        @(posedge ref_clk);
        result_valid   <= 1'b1;
        result_data    <= v;
        result_channel <= c;
        @(posedge ref_clk);
        result_valid <= 1'b0;
        result_data  <= ~v;
        #1;
    endtask
    // Pulses calibration write (bit 0) and the mode events (bits 3:1).
    task automatic strobe(input logic [3:0] m);
        @(posedge ref_clk);
        {ev, cal_coeff_write} <= m;
        @(posedge ref_clk);
        {ev, cal_coeff_write} <= 4'h0;
        #1;
    endtask
    // Cuts a hang short.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            end_sim;
        end
    end
    // Main sequence.
    initial begin
        {result_valid, cal_coeff_write, ev, result_data} = '0;
        {result_channel, error_bits} = '0;
        restart_n = 1'b1;
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        tick(3);
        check("pin after reset", 16'(data_ready_n), 16'h0);
        rd_status(STATUS_RESET);
        rd_status(st_exp(1'b0, 1'b0, 1'b0, 4'h0));
        u_cst_host_model.send(1'b0, STATUS_SEL, 1'b0);
        tick(0);
        check("write ignored", 16'(status_rvalid), 16'h0);
        u_cst_host_model.send(1'b1, STATUS_SEL, 1'b1);
        tick(0);
        check("disabled ignored", 16'(status_rvalid), 16'h0);
        for (int i = 0; i < 16; i++) begin
            d = 16'($random(seed));
            push(d, 4'(i));
            check("warning", 16'(data_ready_n), 16'h1);
            tick(4);
            check("ready", 16'(data_ready_n), 16'h0);
            rd_status(st_exp(1'b0, 1'b0, 1'b0, 4'(i)));
            rd_data(d);
        end
        old_d = d;
        d = 16'($random(seed));
        u_cst_host_model.send(1'b1, DATA_SEL, 1'b0);
        push(d, 4'h5);
        tick(4);
        check("dropped", 16'(result_dropped), 16'h1);
        check("pin kept", 16'(data_ready_n), 16'h1);
        u_cst_host_model.finish;
        rd_data(old_d);
        clk_en <= 1'b0;
        error_bits <= 8'($random(seed)) | 8'h01;
        tick(2);
        check("frozen", 16'(fifo_ctrl_err), 16'h0);
        clk_en <= 1'b1;
        tick(2);
        check("error mirror", 16'(fifo_ctrl_err), 16'h1);
        rd_status(st_exp(1'b1, 1'b1, 1'b0, 4'hf));
        error_bits <= 8'h00;
        tick(2);
        check("error clear", 16'(fifo_ctrl_err), 16'h0);
        rd_status(st_exp(1'b1, 1'b0, 1'b0, 4'hf));
        for (int k = 1; k < 4; k++) begin
            strobe(4'h1);
            check("cal write", 16'(data_ready_n), 16'h0);
            strobe(4'(1 << k));
            check("mode event", 16'(data_ready_n), 16'h1);
        end
        push(d, 4'h3);
        tick(4);
        restart_n <= 1'b0;
        tick(4);
        check("restart", 16'(data_ready_n), 16'h1);
        restart_n <= 1'b1;
        tick(3);
        end_sim;
    end
endmodule
